/* File: verilog/uei_ep_regs.sv */
`timescale 1ns/1ps
`include "uei_params.svh"

module uei_ep_regs #(
	parameter int DMA_LEN_W = `UEI_DMA_LEN_WIDTH,
	parameter int FREE_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire uei_pkg::uei_events_s events,
	input wire logic iso_mode,
	input wire logic [FREE_W-1:0] fifo_free_bytes,
	output logic ep_irq,
	output uei_pkg::uei_dma_cfg_s dma_cfg,
	output logic memory_ready_flag,
	output logic dma_start_req
);

	localparam int NEV = `UEI_NUM_EVENTS;
	localparam int CFG_LEN_W = `UEI_DMA_LEN_WIDTH;

	// Parameter sanity, refused at elaboration; length must fit the carrier
	if (DMA_LEN_W < 1 || DMA_LEN_W > CFG_LEN_W) begin : g_bad_len
		$error("DMA length width must be 1..20");
	end
	if (FREE_W < 6 || FREE_W > 16) begin : g_bad_free
		$error("Free space width must be 6..16");
	end

	uei_pkg::uei_reg_e rd_reg;
	uei_pkg::uei_reg_e wr_reg;
	logic wr_en;
	logic [31:0] wr_data;
	logic [31:0] rd_data;
	logic unused_guard;

	logic [NEV-1:0] mask;
	logic [NEV-1:0] next_mask;
	logic [NEV-1:0] pending;
	logic [NEV-1:0] set_ev;
	logic [NEV-1:0] clr_ev;
	logic [31:0] dma_addr;
	logic [31:0] next_dma_addr;
	logic [DMA_LEN_W-1:0] dma_len;
	logic [DMA_LEN_W-1:0] next_dma_len;
	logic ready_bit;
	logic next_ready_bit;
	logic thresh_bit;
	logic next_thresh_bit;
	logic next_ep_irq;
	logic next_dma_start_req;
	logic [FREE_W-1:0] thresh_bytes;

	// APB slave front end
	uei_apb_slave u_apb (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.rd_data(rd_data),
		.rd_reg(rd_reg),
		.wr_en(wr_en),
		.wr_reg(wr_reg),
		.wr_data(wr_data),
		.pready(pready),
		.prdata_unused_guard(unused_guard),
		.prdata(prdata),
		.pslverr(pslverr)
	);

	// Event strobes mapped onto pending bit positions
	always_comb begin
		set_ev = '0;
		set_ev[`UEI_BIT_CLRFEAT] = events.clear_feature;
		set_ev[`UEI_BIT_BUSERR] = events.sysbus_fault;
		set_ev[`UEI_BIT_DMA] = events.dma_done;
		set_ev[`UEI_BIT_ALT] = events.alt_setting;
		set_ev[`UEI_BIT_TOKEN] = events.token_rx;
		set_ev[`UEI_BIT_STALL] = events.stall;
	end

	// Clear register: ones clear, zeros leave flags alone
	always_comb begin
		clr_ev = '0;
		if (wr_en && wr_reg == uei_pkg::UEI_REG_CLEAR) begin
			clr_ev = wr_data[NEV-1:0];
		end
	end

	// Sticky pending flags
	uei_pending #(
		.NUM(NEV)
	) u_pending (
		.pclk(pclk),
		.presetn(presetn),
		.set_ev(set_ev),
		.clr_ev(clr_ev),
		.pending(pending)
	);

	// Software-written registers
	always_comb begin
		next_mask = mask;
		next_dma_addr = dma_addr;
		next_dma_len = dma_len;
		next_thresh_bit = thresh_bit;
		next_ready_bit = ready_bit;
		if (events.dma_done) begin
			next_ready_bit = 1'b0;
		end
		if (wr_en) begin
			case (wr_reg)
				uei_pkg::UEI_REG_MASK: begin
					next_mask = wr_data[NEV-1:0];
				end
				uei_pkg::UEI_REG_DMA_ADDR: begin
					next_dma_addr = wr_data;
				end
				uei_pkg::UEI_REG_DMA_LEN: begin
					next_dma_len = wr_data[DMA_LEN_W-1:0];
				end
				uei_pkg::UEI_REG_CTRL: begin
					next_ready_bit = wr_data[`UEI_CTRL_READY_BIT];
					next_thresh_bit = wr_data[`UEI_CTRL_THRESH_BIT];
				end
				default: begin
					next_mask = mask;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= '0;
			dma_addr <= `UEI_RESET_WORD;
			dma_len <= '0;
			ready_bit <= 1'b0;
			thresh_bit <= 1'b0;
		end else begin
			mask <= next_mask;
			dma_addr <= next_dma_addr;
			dma_len <= next_dma_len;
			ready_bit <= next_ready_bit;
			thresh_bit <= next_thresh_bit;
		end
	end

	// Read mux; reserved bits read zero, clear register reads zero
	always_comb begin
		rd_data = `UEI_RESET_WORD;
		case (rd_reg)
			uei_pkg::UEI_REG_MASK: begin
				rd_data[NEV-1:0] = mask;
			end
			uei_pkg::UEI_REG_PEND: begin
				rd_data[NEV-1:0] = pending;
			end
			uei_pkg::UEI_REG_DMA_ADDR: begin
				rd_data = dma_addr;
			end
			uei_pkg::UEI_REG_DMA_LEN: begin
				rd_data[DMA_LEN_W-1:0] = dma_len;
			end
			uei_pkg::UEI_REG_CTRL: begin
				rd_data[`UEI_CTRL_READY_BIT] = ready_bit;
				rd_data[`UEI_CTRL_THRESH_BIT] = thresh_bit;
			end
			default: begin
				rd_data = `UEI_RESET_WORD;
			end
		endcase
	end

	// Threshold: bit set selects 16 bytes, clear selects 32
	assign thresh_bytes = thresh_bit ? FREE_W'(`UEI_THRESH_LOW_BYTES)
		: FREE_W'(`UEI_THRESH_HIGH_BYTES);

	// Interrupt and DMA start request
	always_comb begin
		next_ep_irq = |(pending & mask);
		next_dma_start_req = ready_bit && !events.dma_done
			&& (!iso_mode || fifo_free_bytes > thresh_bytes);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ep_irq <= 1'b0;
			dma_start_req <= 1'b0;
			memory_ready_flag <= 1'b0;
			dma_cfg <= '0;
		end else begin
			ep_irq <= next_ep_irq;
			dma_start_req <= next_dma_start_req;
			memory_ready_flag <= next_ready_bit;
			dma_cfg.dma_start_address <= next_dma_addr;
			dma_cfg.dma_byte_count <= CFG_LEN_W'(next_dma_len); // Zero-extends a narrow count
		end
	end

endmodule

/* File: inc/uei_params.svh */
`ifndef UEI_PARAMS_SVH
`define UEI_PARAMS_SVH

`define UEI_ADDR_CTRL 32'hFFF0604C
`define UEI_ADDR_MASK 32'hFFF06050
`define UEI_ADDR_CLEAR 32'hFFF06054
`define UEI_ADDR_PEND 32'hFFF06058
`define UEI_ADDR_DMA_ADDR 32'hFFF0605C
`define UEI_ADDR_DMA_LEN 32'hFFF06060

`define UEI_NUM_EVENTS 6
`define UEI_BIT_STALL 0
`define UEI_BIT_TOKEN 1
`define UEI_BIT_ALT 2
`define UEI_BIT_DMA 3
`define UEI_BIT_BUSERR 4
`define UEI_BIT_CLRFEAT 5

`define UEI_CTRL_READY_BIT 2
`define UEI_CTRL_THRESH_BIT 4

`define UEI_DMA_LEN_WIDTH 20
`define UEI_RESET_WORD 32'h00000000
`define UEI_THRESH_LOW_BYTES 16
`define UEI_THRESH_HIGH_BYTES 32

`endif

/* File: inc/uei_pkg.sv */
`include "uei_params.svh"

package uei_pkg;

	// Register selected by an APB address
	typedef enum logic [2:0] {
		UEI_REG_NONE,
		UEI_REG_CTRL,
		UEI_REG_MASK,
		UEI_REG_CLEAR,
		UEI_REG_PEND,
		UEI_REG_DMA_ADDR,
		UEI_REG_DMA_LEN
	} uei_reg_e;

	// Event strobes, one bit per interrupt source
	typedef struct packed {
		logic clear_feature;
		logic sysbus_fault;
		logic dma_done;
		logic alt_setting;
		logic token_rx;
		logic stall;
	} uei_events_s;

	// DMA programming handed to the datapath
	typedef struct packed {
		logic [31:0] dma_start_address;
		logic [`UEI_DMA_LEN_WIDTH-1:0] dma_byte_count;
	} uei_dma_cfg_s;

	// Address decode, used by both phases of the slave
	function automatic uei_reg_e uei_decode(input logic [31:0] addr);
		case (addr)
			`UEI_ADDR_CTRL: uei_decode = UEI_REG_CTRL;
			`UEI_ADDR_MASK: uei_decode = UEI_REG_MASK;
			`UEI_ADDR_CLEAR: uei_decode = UEI_REG_CLEAR;
			`UEI_ADDR_PEND: uei_decode = UEI_REG_PEND;
			`UEI_ADDR_DMA_ADDR: uei_decode = UEI_REG_DMA_ADDR;
			`UEI_ADDR_DMA_LEN: uei_decode = UEI_REG_DMA_LEN;
			default: uei_decode = UEI_REG_NONE;
		endcase
	endfunction

endpackage

/* File: verilog/uei_apb_slave.sv */
`timescale 1ns/1ps
`include "uei_params.svh"

module uei_apb_slave (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] rd_data,
	output uei_pkg::uei_reg_e rd_reg,
	output logic wr_en,
	output uei_pkg::uei_reg_e wr_reg,
	output logic [31:0] wr_data,
	output logic pready,
	output logic prdata_unused_guard,
	output logic [31:0] prdata,
	output logic pslverr
);

	logic next_pready;
	logic next_pslverr;
	logic [31:0] next_prdata;
	logic setup;

	// Decode shared by read mux and write strobe
	assign rd_reg = uei_pkg::uei_decode(paddr);
	assign wr_reg = rd_reg;
	assign wr_data = pwdata;
	assign setup = psel && !penable;
	assign prdata_unused_guard = 1'b0;

	// Write lands on the completing access edge only
	assign wr_en = psel && penable && pready && pwrite;

	// Answer one cycle after setup: one access cycle, no waits
	always_comb begin
		next_pready = setup;
		next_pslverr = setup && (rd_reg == uei_pkg::UEI_REG_NONE);
		next_prdata = prdata;
		if (setup) begin
			next_prdata = pwrite ? `UEI_RESET_WORD : rd_data;
		end
	end

	// Answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `UEI_RESET_WORD;
		end else begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

endmodule

/* File: verilog/uei_pending.sv */
`timescale 1ns/1ps

module uei_pending #(
	parameter int NUM = 6
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [NUM-1:0] set_ev,
	input wire logic [NUM-1:0] clr_ev,
	output logic [NUM-1:0] pending
);

	logic [NUM-1:0] next_pending;

	// Flag count refused at elaboration when empty
	if (NUM < 1) begin : g_bad_num
		$error("uei_pending needs at least one flag");
	end

	// Per-flag sticky bit, event beats a same-cycle clear
	for (genvar i = 0; i < NUM; i++) begin : g_flag
		assign next_pending[i] = set_ev[i] | (pending[i] & ~clr_ev[i]);
	end

	// Flag registers, zero at reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending <= '0;
		end else begin
			pending <= next_pending;
		end
	end

endmodule

/* File: verif/uei_ep_regs_assertions.sv */
`timescale 1ns/1ps
`include "uei_params.svh"
module uei_ep_regs_checker #(
	parameter int DMA_LEN_W = 20,
	parameter int FREE_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire uei_pkg::uei_events_s events,
	input wire logic iso_mode,
	input wire logic [FREE_W-1:0] fifo_free_bytes,
	input wire logic ep_irq,
	input wire uei_pkg::uei_dma_cfg_s dma_cfg,
	input wire logic memory_ready_flag,
	input wire logic dma_start_req
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [5:0] pend, mask, next_pend, next_mask;
	logic wr, rq, mapped, irq_exp;
	// Expected request level from the shadow flags
	assign irq_exp = |(pend & mask);
	// Bus phase decode
	assign wr = psel && penable && pready && pwrite;
	assign rq = psel && !penable;
	assign mapped = paddr inside {`UEI_ADDR_CTRL, `UEI_ADDR_MASK, `UEI_ADDR_CLEAR,
		`UEI_ADDR_PEND, `UEI_ADDR_DMA_ADDR, `UEI_ADDR_DMA_LEN};
	// Shadow flags, event beats clear
	always_comb begin
		next_mask = (wr && paddr == `UEI_ADDR_MASK) ? pwdata[5:0] : mask;
		next_pend = pend & ~((wr && paddr == `UEI_ADDR_CLEAR) ? pwdata[5:0] : 6'h00);
		next_pend = next_pend | events;
	end
	// Shadow registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend <= 6'h00;
			mask <= 6'h00;
		end else begin
			pend <= next_pend;
			mask <= next_mask;
		end
	end
	irq_follows_a: assert property (ep_irq == $past(irq_exp))
		else $error("irq mismatch");
	pend_read_a: assert property (rq && !pwrite && paddr == `UEI_ADDR_PEND
		|=> prdata == {26'h0, $past(pend)}) else $error("pending read");
	mask_read_a: assert property (rq && !pwrite && paddr == `UEI_ADDR_MASK
		|=> prdata == {26'h0, $past(mask)}) else $error("mask read");
	addr_write_a: assert property (wr && paddr == `UEI_ADDR_DMA_ADDR
		|=> dma_cfg.dma_start_address == $past(pwdata)) else $error("address");
	len_write_a: assert property (wr && paddr == `UEI_ADDR_DMA_LEN
		|=> {12'h000, dma_cfg.dma_byte_count} == ($past(pwdata) & 32'h000FFFFF))
		else $error("length");
	ready_write_a: assert property (wr && paddr == `UEI_ADDR_CTRL
		|=> memory_ready_flag == |($past(pwdata) & 32'h00000004)) else $error("ready");
	start_gate_a: assert property (!memory_ready_flag |=> !dma_start_req)
		else $error("start without ready");
	iso_floor_a: assert property (iso_mode && fifo_free_bytes <= `UEI_THRESH_LOW_BYTES
		|=> !dma_start_req) else $error("start below threshold");
	done_drop_a: assert property (events.dma_done && !(wr && paddr == `UEI_ADDR_CTRL)
		|=> !memory_ready_flag) else $error("ready kept");
	zero_wait_a: assert property (rq |=> pready ##1 !pready) else $error("pready");
	unmapped_err_a: assert property (rq && !mapped |=> pslverr && prdata == 32'h0)
		else $error("unmapped");
	irq_c: cover property ($rose(ep_irq));
	race_c: cover property (events.stall && wr && paddr == `UEI_ADDR_CLEAR);
	err_c: cover property (pslverr);
endmodule
bind uei_ep_regs uei_ep_regs_checker #(.DMA_LEN_W(DMA_LEN_W), .FREE_W(FREE_W))
	uei_ep_regs_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .events(events), .iso_mode(iso_mode),
	.fifo_free_bytes(fifo_free_bytes), .ep_irq(ep_irq), .dma_cfg(dma_cfg),
	.memory_ready_flag(memory_ready_flag), .dma_start_req(dma_start_req));

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`include "uei_params.svh"
module testbench;
	logic pclk, presetn, psel, penable, pwrite, iso_mode, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic pready, pslverr, ep_irq, memory_ready_flag, dma_start_req;
	logic [7:0] fifo_free_bytes;
	uei_pkg::uei_events_s events;
	uei_pkg::uei_dma_cfg_s dma_cfg;
	int bad_count, checks;
	uei_ep_regs uei_ep_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
		.iso_mode(iso_mode), .fifo_free_bytes(fifo_free_bytes), .ep_irq(ep_irq),
		.dma_cfg(dma_cfg), .memory_ready_flag(memory_ready_flag),
		.dma_start_req(dma_start_req));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// One APB transfer; ev pulses during the access phase
	task automatic apb(input logic w, input logic [31:0] a, d, input logic [5:0] ev);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		events <= ev;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 16) begin
			n++;
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		events <= '0;
		if (pready !== 1'b1) begin
			chk("pready", 32'h1, {31'h0, pready});
			give_verdict();
		end
	endtask
	task automatic wr(input logic [31:0] a, d);
		apb(1'b1, a, d, 6'h00);
	endtask
	task automatic rdchk(input string what, input logic [31:0] a, exp);
		apb(1'b0, a, 32'h0, 6'h00);
		chk(what, exp, rd);
	endtask
	task automatic pulse(input logic [5:0] ev);
		@(posedge pclk);
		events <= ev;
		@(posedge pclk);
		events <= '0;
	endtask
	task automatic settle();
		repeat (2) @(posedge pclk);
		#1;
	endtask
	// Reset values, clear register reads zero
	task automatic t_reset();
		for (int i = 0; i < 6; i++) rdchk("reset", 32'hFFF0604C + 4 * i, 32'h0);
		chk("cfg", 32'h0, dma_cfg[31:0]);
		chk("cfg addr", 32'h0, dma_cfg.dma_start_address);
		chk("cfg len", 32'h0, {12'h000, dma_cfg.dma_byte_count});
		chk("outs", 32'h0, {29'h0, ep_irq, memory_ready_flag, dma_start_req});
		$display("reset test done");
	endtask
	// Field widths and read-only pending
	task automatic t_regs();
		wr(`UEI_ADDR_MASK, 32'hFFFFFFFF);
		rdchk("mask", `UEI_ADDR_MASK, 32'h3F);
		wr(`UEI_ADDR_DMA_ADDR, 32'hA5C30F81);
		rdchk("addr", `UEI_ADDR_DMA_ADDR, 32'hA5C30F81);
		wr(`UEI_ADDR_DMA_LEN, 32'hFFFFFFFF);
		rdchk("len", `UEI_ADDR_DMA_LEN, 32'h000FFFFF);
		wr(`UEI_ADDR_PEND, 32'h3F);
		rdchk("pend ro", `UEI_ADDR_PEND, 32'h0);
		wr(`UEI_ADDR_MASK, 32'h0);
		apb(1'b0, 32'hFFF06064, 32'h0, 6'h00);
		chk("slverr", 32'h1, {31'h0, err});
		$display("register test done");
	endtask
	// Each source sets, raises, clears
	task automatic t_events();
		for (int i = 0; i < 6; i++) begin
			pulse(6'h01 << i);
			rdchk("pend", `UEI_ADDR_PEND, 32'h1 << i);
			chk("irq off", 32'h0, {31'h0, ep_irq});
			wr(`UEI_ADDR_MASK, 32'h1 << i);
			settle();
			chk("irq on", 32'h1, {31'h0, ep_irq});
			wr(`UEI_ADDR_CLEAR, ~(32'h1 << i));
			rdchk("zero kept", `UEI_ADDR_PEND, 32'h1 << i);
			wr(`UEI_ADDR_CLEAR, 32'h1 << i);
			rdchk("cleared", `UEI_ADDR_PEND, 32'h0);
			wr(`UEI_ADDR_MASK, 32'h0);
		end
		pulse(6'h01);
		apb(1'b1, `UEI_ADDR_CLEAR, 32'h3F, 6'h01);
		rdchk("race", `UEI_ADDR_PEND, 32'h1);
		$display("event test done");
	endtask
	// Ready bit and start threshold
	task automatic t_dma();
		wr(`UEI_ADDR_CTRL, 32'h14);
		settle();
		chk("ready", 32'h1, {31'h0, memory_ready_flag});
		chk("start", 32'h1, {31'h0, dma_start_req});
		@(posedge pclk);
		iso_mode <= 1'b1;
		fifo_free_bytes <= 8'h10;
		settle();
		chk("at 16", 32'h0, {31'h0, dma_start_req});
		@(posedge pclk);
		fifo_free_bytes <= 8'h11;
		settle();
		chk("over 16", 32'h1, {31'h0, dma_start_req});
		wr(`UEI_ADDR_CTRL, 32'h04);
		settle();
		chk("at 17", 32'h0, {31'h0, dma_start_req});
		@(posedge pclk);
		fifo_free_bytes <= 8'h20;
		settle();
		chk("at 32", 32'h0, {31'h0, dma_start_req});
		@(posedge pclk);
		fifo_free_bytes <= 8'h21;
		settle();
		chk("over 32", 32'h1, {31'h0, dma_start_req});
		pulse(6'h08);
		settle();
		chk("done", 32'h0, {31'h0, memory_ready_flag});
		chk("no start", 32'h0, {31'h0, dma_start_req});
		wr(`UEI_ADDR_CLEAR, 32'h3F);
		$display("dma test done");
	endtask
	// Reset in mid-run clears programmed state
	task automatic t_midreset();
		wr(`UEI_ADDR_MASK, 32'h3F);
		wr(`UEI_ADDR_DMA_ADDR, 32'h5A5A5A5A);
		wr(`UEI_ADDR_DMA_LEN, 32'h00012345);
		wr(`UEI_ADDR_CTRL, 32'h14);
		pulse(6'h3F);
		settle();
		chk("irq set", 32'h1, {31'h0, ep_irq});
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		$display("mid-run reset test done");
	endtask
	// Clock
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Main sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		events = '0;
		iso_mode = 1'b0;
		fifo_free_bytes = 8'h00;
		bad_count = 0;
		checks = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_regs();
		t_events();
		t_dma();
		t_midreset();
		give_verdict();
	end
endmodule
